// ===== dv/lcslm_framer_model.sv
/*
  Framer-side receiver model: takes retimed data on each recovered tick.
  Assumes one-cycle tick strobes synchronous to clk.
*/
module lcslm_framer_model #(
  parameter int CH = 2
) (
  input  wire logic          clk,
  input  wire logic [CH-1:0] recoveredClockOut,
  input  wire logic [CH-1:0] retimedDataOut,
  output logic      [CH-1:0] gotBit
);
  timeunit 1ns;
  timeprecision 1ps;
  // ------
  // Capture
  // ------
  always @(posedge clk) begin
    for (int i = 0; i < CH; i++) begin
      if (recoveredClockOut[i]) begin
        gotBit[i] <= retimedDataOut[i];
      end
    end
  end
endmodule

// ===== dv/lcslm_properties.sv
/*
  Port checks for lcslm_top: bus timing, lock flag, clock and data path.
  Assumes it is bound into lcslm_top with the same parameters.
*/
module lcslm_properties #(
  parameter int CHANNELS      = 12,
  parameter int WIN_REF_TICKS = 4096
) (
  input wire logic                clk,
  input wire logic                rst,
  input wire logic                psel,
  input wire logic                penable,
  input wire logic                pready,
  input wire logic                pslverr,
  input wire logic                singleRefSelectPin,
  input wire logic                t3RateReferenceIn,
  input wire logic [CHANNELS-1:0] lineSignalLos,
  input wire logic [CHANNELS-1:0] recoveredTick,
  input wire logic [CHANNELS-1:0] recoveredData,
  input wire logic [CHANNELS-1:0] recoveredClockOut,
  input wire logic [CHANNELS-1:0] retimedDataOut,
  input wire logic [CHANNELS-1:0] lockLossFlag,
  input wire logic                cpuTimingTick
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // ------
  // Bus
  // ------
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  a_one_wait_state: assert property (psel && penable && !pready |=> pready)
    else $error("answer not one cycle after access");
  a_error_in_access: assert property (pslverr |-> pready && psel && penable)
    else $error("error outside answer");
  // ------
  // Clocks and lock
  // ------
  a_cpu_tick_t3: assert property (
    !singleRefSelectPin && !$past(singleRefSelectPin)
    |=> cpuTimingTick == $past(t3RateReferenceIn))
    else $error("timing tick not from t3 reference");
  a_rec_when_locked: assert property (
    ##1 !lockLossFlag[0] |-> recoveredClockOut[0] == $past(recoveredTick[0]))
    else $error("locked output not recovered tick");
  a_los_sets_loss: assert property (
    lineSignalLos[0] ##1 lineSignalLos[0] |=> lockLossFlag[0])
    else $error("no lock loss under LOS");
  a_clear_needs_sig: assert property (
    $fell(lockLossFlag[0]) |-> !$past(lineSignalLos[0], 2) && !$past(lineSignalLos[0], 3))
    else $error("lock loss cleared under LOS");
  a_retimed_on_tick: assert property (
    recoveredTick[0] |=> retimedDataOut[0] == $past(recoveredData[0]))
    else $error("retimed data not taken on tick");
  a_retimed_held: assert property (
    !recoveredTick[0] |=> $stable(retimedDataOut[0]))
    else $error("retimed data moved without tick");
endmodule

bind lcslm_top lcslm_properties #(.CHANNELS(CHANNELS), .WIN_REF_TICKS(WIN_REF_TICKS)) props (
  .clk, .rst, .psel, .penable, .pready, .pslverr, .singleRefSelectPin, .t3RateReferenceIn,
  .lineSignalLos, .recoveredTick, .recoveredData, .recoveredClockOut, .retimedDataOut,
  .lockLossFlag, .cpuTimingTick
);

// ===== dv/tb_top.sv
/*
  Self-checking bench for lcslm_top with a framer model downstream.
  Assumes references and line clocks are one-cycle tick strobes on clk.
*/
module tb_top import lcslm_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int CH  = 2;
  localparam int WIN = 400;
  // Synthesized ticks expected over WIN single-reference ticks
  localparam int SYN0 = WIN * KHZ_STS1 / KHZ_SINGLE;
  localparam int SYN1 = WIN * KHZ_DS3 / KHZ_SINGLE;
  // ------
  // Signals and model state
  // ------
  logic          clk = 1'b0;
  logic          rst = 1'b1;
  logic [11:0]   paddr = 12'h000;
  logic          psel = 1'b0;
  logic          penable = 1'b0;
  logic          pwrite = 1'b0;
  logic [31:0]   pwdata = 32'h0;
  logic          singleRefSelectPin = 1'b0;
  logic          t3RateReferenceIn = 1'b0;
  logic          rate34mReferenceIn = 1'b0;
  logic          rate51mOrSingleReferenceIn = 1'b0;
  logic [CH-1:0] lineSignalLos = '0;
  logic [CH-1:0] recoveredTick = '0;
  logic [CH-1:0] recoveredData = '0;
  logic [31:0]   prdata, rd, w;
  logic          pready, pslverr, cpuTimingTick, er;
  logic [CH-1:0] recoveredClockOut, retimedDataOut, lockLossFlag, eqDisable, eqGainBoost;
  logic [CH-1:0] gotBit;
  logic          noise = 1'b0;
  logic          tieT3 = 1'b0;
  int            miscompares = 0, checks_done = 0, cyc = 0, pSts = 3, n0, n1;
  int            recPer[CH] = '{4, 7};
  int            per[3] = '{5, 4, 3};
  int            srcOf[3] = '{1, 0, 2};
  int            ord[3] = '{1, 0, 2};
  int            ctrlM[CH];

  initial begin
    forever #12.5 clk = ~clk;
  end

  // Clock source keeps t3 running in every mode; noise proves unused refs ignored
  always @(posedge clk) begin
    cyc <= cyc + 1;
    // Single-rate board: the E3 reference is strapped onto the t3 input
    t3RateReferenceIn <= tieT3 ? (cyc % 5 == 0) : (cyc % 4 == 0);
    rate34mReferenceIn <= noise ? 1'($urandom) : (cyc % 5 == 0);
    rate51mOrSingleReferenceIn <= noise ? 1'($urandom) : (cyc % pSts == 0);
    for (int i = 0; i < CH; i++) begin
      recoveredTick[i] <= (cyc % recPer[i] == 0);
    end
  end

  lcslm_top #(.CHANNELS(CH), .WIN_REF_TICKS(WIN)) DUT (
    .clk, .rst, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
    .singleRefSelectPin, .t3RateReferenceIn, .rate34mReferenceIn,
    .rate51mOrSingleReferenceIn, .lineSignalLos, .recoveredTick, .recoveredData,
    .recoveredClockOut, .retimedDataOut, .lockLossFlag, .eqDisable, .eqGainBoost,
    .cpuTimingTick
  );
  lcslm_framer_model #(.CH(CH)) framer (.clk, .recoveredClockOut, .retimedDataOut, .gotBit);

  // ------
  // Tasks
  // ------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) miscompares++;
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic waitc(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic status(input int c, input logic [31:0] exp);
    apb(1'b0, 12'h080 + 12'(4 * c), 32'h0);
    check(rd, exp);
  endtask

  function automatic logic refBit(input int s, input int ch);
    case (s)
      0: refBit = t3RateReferenceIn;
      1: refBit = rate34mReferenceIn;
      2: refBit = rate51mOrSingleReferenceIn;
      default: refBit = recoveredTick[ch];
    endcase
  endfunction

  // Output must repeat the chosen tick one cycle later; ch below 0 means timing tick
  task automatic follow(input int ch, input int s);
    logic p;
    @(negedge clk);
    p = refBit(s, ch);
    repeat (40) begin
      @(negedge clk);
      check(32'(ch < 0 ? cpuTimingTick : recoveredClockOut[ch]), 32'(p));
      p = refBit(s, ch);
    end
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    #(25 * 90000);
    miscompares++;
    report_and_stop;
  end

  // ------
  // Main sequence
  // ------
  initial begin
    void'($urandom(32'h0294));
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    check(32'(lockLossFlag), 32'h3);
    check(32'({eqDisable, eqGainBoost}), 32'h0);
    apb(1'b1, 12'h000, 32'h1);
    apb(1'b0, 12'h000, 32'h0);
    check(rd, 32'h0);
    apb(1'b0, 12'h100, 32'h0);
    check(32'(er), 32'h1);
    for (int c = 0; c < CH; c++) begin
      apb(1'b0, 12'h040 + 12'(4 * c), 32'h0);
      check(rd, 32'h1);
      status(c, 32'h1);
      for (int r = 0; r < 4; r++) begin
        w = ($urandom & 32'hffff_fffc) | 32'(r);
        ctrlM[c] = int'(w & 32'hf);
        apb(1'b1, 12'h040 + 12'(4 * c), w);
        apb(1'b0, 12'h040 + 12'(4 * c), 32'h0);
        check(rd, 32'(ctrlM[c]));
        check(32'(eqDisable[c]), 32'(ctrlM[c] >> 2 & 1));
        check(32'(eqGainBoost[c]), 32'(ctrlM[c] >> 3));
      end
    end
    recoveredData <= CH'($urandom);
    apb(1'b1, 12'h044, 32'h1);
    for (int k = 0; k < 3; k++) begin
      noise <= (ord[k] == 1);
      recPer[0] <= per[ord[k]];
      // Software turns the equalizer off for square E3 pulses on short cable
      apb(1'b1, 12'h040, 32'(ord[k]) | (ord[k] == 0 ? 32'h4 : 32'h0));
      waitc(3 * WIN * per[ord[k]]);
      check(32'(lockLossFlag), 32'h2);
      check(32'(eqDisable[0]), 32'(ord[k] == 0));
      status(0, 32'h0);
      follow(0, 3);
      check(32'(gotBit[0]), 32'(recoveredData[0]));
      if (ord[k] == 1) begin
        lineSignalLos[0] <= 1'b1;
        waitc(3);
        check(32'(lockLossFlag[0]), 32'h1);
        status(0, 32'h3);
        follow(0, 0);
        lineSignalLos[0] <= 1'b0;
        waitc(3 * WIN * 4);
        check(32'(lockLossFlag[0]), 32'h0);
      end
      recPer[0] <= 7;
      waitc(3 * WIN * per[ord[k]]);
      check(32'(lockLossFlag[0]), 32'h1);
      follow(0, srcOf[ord[k]]);
      follow(1, 0);
    end
    noise <= 1'b0;
    pSts <= 6;
    singleRefSelectPin <= 1'b1;
    waitc(4);
    apb(1'b0, 12'h000, 32'h0);
    check(rd, 32'h1);
    // Both channels out of lock: outputs carry the synthesized rate ticks
    n0 = 0;
    n1 = 0;
    repeat (6 * WIN) begin
      @(negedge clk);
      n0 += int'(recoveredClockOut[0]);
      n1 += int'(recoveredClockOut[1]);
    end
    check(32'(n0 >= SYN0 - 1 && n0 <= SYN0 + 2), 32'h1);
    check(32'(n1 >= SYN1 - 1 && n1 <= SYN1 + 2), 32'h1);
    follow(-1, 2);
    singleRefSelectPin <= 1'b0;
    waitc(4);
    follow(-1, 0);
    tieT3 <= 1'b1;
    waitc(4);
    follow(-1, 1);
    report_and_stop;
  end
endmodule

// ===== src/lcslm_lock_mon.sv
/*
  Per-channel lock monitor: counts recovered and reference ticks over a
  window of reference ticks and decides lock or loss of lock.
  Assumes tick strobes are synchronous one-cycle pulses.
*/
module lcslm_lock_mon import lcslm_pkg::*; #(
  parameter int WIN = WIN_REF_DEF
) (
  input  wire logic  clk,
  input  wire logic  rst,
  lcslm_mon_if.mon   mon
);

  localparam logic [CNT_W-1:0] WIN_LAST = CNT_W'(WIN - 1);

  lcslm_lock_e      state;
  lcslm_lock_e      next_state;
  logic [CNT_W-1:0] winCnt;
  logic [CNT_W-1:0] next_winCnt;
  logic [CNT_W-1:0] recCnt;
  logic [CNT_W-1:0] next_recCnt;

  // ------------------------------------------------------------------
  // Window counting
  // ------------------------------------------------------------------
  always_comb begin
    next_state  = state;
    next_winCnt = winCnt;
    next_recCnt = recCnt;
    // Saturate so a runaway line clock cannot wrap into the band
    if (mon.recTick && recCnt != '1)
      next_recCnt = recCnt + 1'b1;
    if (mon.refTick)
      next_winCnt = winCnt + 1'b1;
    if (mon.los) begin
      next_state  = LM_TRAIN;
      next_winCnt = '0;
      next_recCnt = '0;
    end else if (mon.refTick && winCnt == WIN_LAST) begin
      case (inBand(next_recCnt, mon.expected))
        1'b1:    next_state = LM_LOCK;
        default: next_state = LM_TRAIN;
      endcase
      next_winCnt = '0;
      next_recCnt = '0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state  <= LM_TRAIN;
      winCnt <= '0;
      recCnt <= '0;
    end else begin
      state  <= next_state;
      winCnt <= next_winCnt;
      recCnt <= next_recCnt;
    end
  end

  assign mon.lockLoss = (state != LM_LOCK);

endmodule

// ===== src/lcslm_mon_if.sv
/*
  Link between the top level and one channel's lock monitor.
  Assumes both ends run on the same clock.
*/
interface lcslm_mon_if import lcslm_pkg::*;;
  logic             refTick;
  logic             recTick;
  logic             los;
  logic [CNT_W-1:0] expected;
  logic             lockLoss;

  modport top (output refTick, output recTick, output los, output expected,
               input lockLoss);
  modport mon (input refTick, input recTick, input los, input expected,
               output lockLoss);
endinterface

// ===== src/lcslm_pkg.sv
/*
  Constants, register map and helper functions for the line clock select
  and lock monitor. Assumes all line and reference clocks reach the block
  as synchronous one-cycle tick strobes from the analog prescalers.
*/
package lcslm_pkg;

  // ------------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------------
  localparam logic [11:0] GLOBAL_OFS   = 12'h000;
  localparam logic [11:0] CH_CTRL_BASE = 12'h040;
  localparam logic [11:0] CH_STAT_BASE = 12'h080;
  localparam int          CTRL_W       = 4;
  localparam int          CTRL_RATE_LO = 0;
  localparam int          CTRL_EQ_DIS  = 2;
  localparam int          CTRL_EQ_GAIN = 3;
  localparam logic [3:0]  CTRL_RESET   = 4'h1;
  localparam int          STAT_LOL     = 0;
  localparam int          STAT_LOS     = 1;
  localparam int          GLOB_SINGLE  = 0;

  // ------------------------------------------------------------------
  // Rates and timing
  // ------------------------------------------------------------------
  localparam logic [1:0]  RATE_E3      = 2'h0;
  localparam logic [1:0]  RATE_DS3     = 2'h1;
  localparam logic [1:0]  RATE_STS1    = 2'h2;
  localparam int          KHZ_E3       = 34368;
  localparam int          KHZ_DS3      = 44736;
  localparam int          KHZ_STS1     = 51840;
  localparam int          KHZ_SINGLE   = 12288;
  localparam int          TOL_DIVISOR  = 200;
  localparam int          WIN_REF_DEF  = 4096;
  localparam int          CNT_W        = 16;
  localparam int          ACC_W        = 18;

  typedef enum logic [1:0] {
    LM_TRAIN = 2'b01,
    LM_LOCK  = 2'b10
  } lcslm_lock_e;

  // ------------------------------------------------------------------
  // Functions
  // ------------------------------------------------------------------
  function automatic int rateKhz(input logic [1:0] rate);
    case (rate)
      RATE_E3:   rateKhz = KHZ_E3;
      RATE_STS1: rateKhz = KHZ_STS1;
      default:   rateKhz = KHZ_DS3;
    endcase
  endfunction

  // Single mode scales the window to the line rate; dedicated refs are 1:1
  function automatic logic [CNT_W-1:0] expectedCount(input logic [1:0] rate,
                                                     input logic       single,
                                                     input int         win);
    if (single)
      expectedCount = CNT_W'((win * rateKhz(rate)) / KHZ_SINGLE);
    else
      expectedCount = CNT_W'(win);
  endfunction

  function automatic logic inBand(input logic [CNT_W-1:0] rec,
                                 input logic [CNT_W-1:0] exp);
    logic [CNT_W-1:0] diff;
    diff   = (rec > exp) ? rec - exp : exp - rec;
    inBand = (diff < exp / CNT_W'(TOL_DIVISOR));
  endfunction

  function automatic logic [11:0] chAddr(input logic [11:0] base, input int c);
    chAddr = base + 12'(c * 4);
  endfunction

endpackage

// ===== src/lcslm_top.sv
/*
  Line clock selection and lock supervision for a multi-channel line
  interface, with an APB register slave. Assumes all clocks arrive as
  synchronous tick strobes and the loss-of-signal detector is outside.
*/
// The implementer's own choices: the APB interface to the registers and the placing of the registers.

module lcslm_top import lcslm_pkg::*; #(
  parameter int CHANNELS      = 12,
  parameter int WIN_REF_TICKS = WIN_REF_DEF
) (
  input  wire logic                clk,
  input  wire logic                rst,
  input  wire logic [11:0]         paddr,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [31:0]         pwdata,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  input  wire logic                singleRefSelectPin,
  input  wire logic                t3RateReferenceIn,
  input  wire logic                rate34mReferenceIn,
  input  wire logic                rate51mOrSingleReferenceIn,
  input  wire logic [CHANNELS-1:0] lineSignalLos,
  input  wire logic [CHANNELS-1:0] recoveredTick,
  input  wire logic [CHANNELS-1:0] recoveredData,
  output logic      [CHANNELS-1:0] recoveredClockOut,
  output logic      [CHANNELS-1:0] retimedDataOut,
  output logic      [CHANNELS-1:0] lockLossFlag,
  output logic      [CHANNELS-1:0] eqDisable,
  output logic      [CHANNELS-1:0] eqGainBoost,
  output logic                     cpuTimingTick
);

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  logic [CTRL_W-1:0]   chCtrl         [CHANNELS];
  logic [CTRL_W-1:0]   next_chCtrl    [CHANNELS];
  logic [ACC_W-1:0]    synthAcc       [CHANNELS];
  logic [ACC_W-1:0]    next_synthAcc  [CHANNELS];
  logic                singleReferenceOperation;
  logic [31:0]         next_prdata;
  logic                next_pready;
  logic                next_pslverr;
  logic [CHANNELS-1:0] next_recoveredClockOut;
  logic [CHANNELS-1:0] next_retimedDataOut;
  logic [CHANNELS-1:0] next_eqDisable;
  logic [CHANNELS-1:0] next_eqGainBoost;
  logic [CHANNELS-1:0] synthTick;
  logic [CHANNELS-1:0] countRefTick;
  logic [CHANNELS-1:0] monLockLoss;
  logic                next_cpuTimingTick;

  lcslm_mon_if monIf [CHANNELS] ();

  // ------------------------------------------------------------------
  // Reference selection
  // ------------------------------------------------------------------
  // Dedicated mode: each rate has its own input, DS3 also times the CPU port
  function automatic logic pickRef(input logic [1:0] rate,
                                   input logic       single);
    if (single)
      pickRef = rate51mOrSingleReferenceIn;
    else
      case (rate)
        RATE_E3:   pickRef = rate34mReferenceIn;
        RATE_STS1: pickRef = rate51mOrSingleReferenceIn;
        default:   pickRef = t3RateReferenceIn;
      endcase
  endfunction

  always_comb begin
    for (int c = 0; c < CHANNELS; c++) begin
      countRefTick[c] = pickRef(chCtrl[c][CTRL_RATE_LO +: 2],
                                singleReferenceOperation);
    end
  end

  // ------------------------------------------------------------------
  // Rate synthesis from the single reference
  // ------------------------------------------------------------------
  // Fractional accumulator; limited to one output tick per system clock,
  // so it needs ticks that are sparse against clk.
  always_comb begin
    for (int c = 0; c < CHANNELS; c++) begin
      next_synthAcc[c] = synthAcc[c];
      synthTick[c]     = (synthAcc[c] >= ACC_W'(KHZ_SINGLE));
      if (synthTick[c])
        next_synthAcc[c] = next_synthAcc[c] - ACC_W'(KHZ_SINGLE);
      if (singleReferenceOperation && rate51mOrSingleReferenceIn)
        next_synthAcc[c] = next_synthAcc[c]
                           + ACC_W'(rateKhz(chCtrl[c][CTRL_RATE_LO +: 2]));
      if (!singleReferenceOperation)
        next_synthAcc[c] = '0;
    end
  end

  // ------------------------------------------------------------------
  // Lock monitors
  // ------------------------------------------------------------------
  for (genvar c = 0; c < CHANNELS; c++) begin : g_ch
    assign monIf[c].refTick  = countRefTick[c];
    assign monIf[c].recTick  = recoveredTick[c];
    assign monIf[c].los      = lineSignalLos[c];
    assign monIf[c].expected = expectedCount(chCtrl[c][CTRL_RATE_LO +: 2],
                                             singleReferenceOperation,
                                             WIN_REF_TICKS);
    assign monLockLoss[c]    = monIf[c].lockLoss;

    lcslm_lock_mon #(
      .WIN (WIN_REF_TICKS)
    ) u_mon (
      .clk (clk),
      .rst (rst),
      .mon (monIf[c])
    );
  end

  // ------------------------------------------------------------------
  // Clock and data outputs
  // ------------------------------------------------------------------
  always_comb begin
    for (int c = 0; c < CHANNELS; c++) begin
      if (monLockLoss[c])
        next_recoveredClockOut[c] = singleReferenceOperation ?
                                    synthTick[c] : countRefTick[c];
      else
        next_recoveredClockOut[c] = recoveredTick[c];
      // Data moves only on recovered-clock ticks so that, while the channel is locked,
      // the decoder sees it aligned with the clock it is sampled by
      next_retimedDataOut[c] = recoveredTick[c] ?
                               recoveredData[c] : retimedDataOut[c];
      next_eqDisable[c]      = chCtrl[c][CTRL_EQ_DIS];
      next_eqGainBoost[c]    = chCtrl[c][CTRL_EQ_GAIN];
    end
    next_cpuTimingTick = singleReferenceOperation ?
                         rate51mOrSingleReferenceIn : t3RateReferenceIn;
  end

  // ------------------------------------------------------------------
  // APB slave
  // ------------------------------------------------------------------
  // One wait state: pready rises in the second access cycle
  always_comb begin
    logic hit;
    hit          = 1'b0;
    next_pready  = 1'b0;
    next_pslverr = 1'b0;
    next_prdata  = prdata;
    for (int c = 0; c < CHANNELS; c++) begin
      next_chCtrl[c] = chCtrl[c];
    end
    if (psel && penable && !pready) begin
      next_pready = 1'b1;
      next_prdata = 32'h0;
      if (paddr == GLOBAL_OFS) begin
        hit                     = 1'b1;
        next_prdata[GLOB_SINGLE] = singleReferenceOperation;
      end
      for (int c = 0; c < CHANNELS; c++) begin
        if (paddr == chAddr(CH_CTRL_BASE, c)) begin
          hit = 1'b1;
          next_prdata[CTRL_W-1:0] = chCtrl[c];
          if (pwrite)
            next_chCtrl[c] = pwdata[CTRL_W-1:0];
        end
        if (paddr == chAddr(CH_STAT_BASE, c)) begin
          hit = 1'b1;
          next_prdata[STAT_LOL] = lockLossFlag[c];
          next_prdata[STAT_LOS] = lineSignalLos[c];
        end
      end
      if (!hit)
        next_pslverr = 1'b1;
    end
  end

  // ------------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int c = 0; c < CHANNELS; c++) begin
        chCtrl[c]   <= CTRL_RESET;
        synthAcc[c] <= '0;
      end
      singleReferenceOperation <= 1'b0;
      prdata                   <= 32'h0;
      pready                   <= 1'b0;
      pslverr                  <= 1'b0;
      recoveredClockOut        <= '0;
      retimedDataOut           <= '0;
      lockLossFlag             <= '1;
      eqDisable                <= '0;
      eqGainBoost              <= '0;
      cpuTimingTick            <= 1'b0;
    end else begin
      for (int c = 0; c < CHANNELS; c++) begin
        chCtrl[c]   <= next_chCtrl[c];
        synthAcc[c] <= next_synthAcc[c];
      end
      singleReferenceOperation <= singleRefSelectPin;
      prdata                   <= next_prdata;
      pready                   <= next_pready;
      pslverr                  <= next_pslverr;
      recoveredClockOut        <= next_recoveredClockOut;
      retimedDataOut           <= next_retimedDataOut;
      lockLossFlag             <= monLockLoss;
      eqDisable                <= next_eqDisable;
      eqGainBoost              <= next_eqGainBoost;
      cpuTimingTick            <= next_cpuTimingTick;
    end
  end

endmodule
